// ---- rtl/piu_map.svh ----
// Functional notes
// - Levels 0 to 16; level 0 masks source.
// - Nonmaskable request is level 16, always taken.
// - Nonmaskable edge polarity chosen by control bit.
// - Nonmaskable acceptance loads mask level 15.
// - Control register mirrors nonmaskable pin level.
// - Per pin: low level or falling edge.
// - Pin priorities 0-15 in registers a, b.
// - Level mode request follows pin low; flag live.
// - Falling edge latches request until accepted.
// - Writing zero to flag clears latched request.
// - Pin acceptance loads mask with its level.
// - Every source has its own vector.
// - Peripheral priorities 0-15 in registers d-h.
// - Peripheral acceptance loads mask with its level.
// - Vector table address computed from vector number.
// - Shared field sources ranked in fixed order.
// - Reset sets all priorities to zero.
// - Equal levels granted in fixed default order.
// - Control bit 15 reads 1 pin high, 0 low.
// - Byte, halfword and word accesses supported.
// - Priority registers 16-bit, four-bit fields.
`ifndef PIU_MAP_SVH
`define PIU_MAP_SVH

`define PIU_NSRC 27
`define PIU_NPIN 7
`define PIU_NPER 20
`define PIU_NPRI 8
`define PIU_NREG 10

`define PIU_IDX_PRI_A 32'hFFFF8348
`define PIU_IDX_PRI_B 32'hFFFF834A
`define PIU_IDX_PRI_C 32'hFFFF834C
`define PIU_IDX_PRI_D 32'hFFFF834E
`define PIU_IDX_PRI_E 32'hFFFF8350
`define PIU_IDX_PRI_F 32'hFFFF8352
`define PIU_IDX_PRI_G 32'hFFFF8354
`define PIU_IDX_PRI_H 32'hFFFF8356
`define PIU_IDX_CTRL 32'hFFFF8358
`define PIU_IDX_FLAGS 32'hFFFF835A
`define PIU_CTRL_SLOT 8
`define PIU_FLAGS_SLOT 9

`define PIU_PRI_RST 16'h0000
`define PIU_CTRL_RST 16'h0000
`define PIU_CTRL_WMASK 16'h01F3
`define PIU_CTRL_NMI_LVL 15
`define PIU_CTRL_NONMASKABLE_EDGE_SELECT 8
`define PIU_PIN_RST 7'h7E
`define PIU_NMI_LEVEL 5'h10
`define PIU_NMI_MASK 4'hF
`define PIU_NMI_SRC 5'h00

`define PIU_HSIZE_BYTE 3'h0
`define PIU_HSIZE_HALF 3'h1
`define PIU_LANE0 2'h0
`define PIU_LANE1 2'h1

// Flag and sense bit position for each external pin, pin 0 first.
`define PIU_PIN_POS '{4'h7, 4'h6, 4'h5, 4'h4, 4'h1, 4'h0}

// Vector number per source: nonmaskable, six pins, then peripherals.
`define PIU_VEC_TABLE '{8'h0B, \
  8'h40, 8'h41, 8'h42, 8'h43, 8'h46, 8'h47, \
  8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h60, 8'h61, 8'h64, \
  8'h68, 8'h69, 8'h6C, 8'h84, 8'h85, 8'h86, 8'h87, 8'h8A, \
  8'h90, 8'h94, 8'h98, 8'h99}

// Priority field per source as {register, nibble}.
`define PIU_FLD_TABLE '{5'h00, \
  5'h03, 5'h02, 5'h01, 5'h00, 5'h05, 5'h04, \
  5'h0F, 5'h0F, 5'h0F, 5'h0F, 5'h0E, 5'h0D, 5'h0D, 5'h0C, \
  5'h13, 5'h13, 5'h12, 5'h14, 5'h14, 5'h14, 5'h14, 5'h1B, \
  5'h19, 5'h18, 5'h1F, 5'h1F}

`endif

// ---- rtl/piu_pkg.sv ----
package piu_pkg;
  typedef logic [4:0] piu_level_t;
  typedef logic [7:0] piu_vec_t;
  typedef logic [4:0] piu_src_t;
  typedef logic [4:0] piu_fld_t;
  typedef logic [15:0] piu_reg_t;
endpackage

// ---- rtl/piu_top.sv ----
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`include "piu_map.svh"

module piu_top
  import piu_pkg::*;
(
  input wire logic hclk, // System clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic nmi_pin, // Nonmaskable request pin.
  input wire logic [5:0] irq_n_pins, // External request pins, low active.
  input wire logic [19:0] periph_req, // Peripheral request levels.
  input wire logic [3:0] cpu_mask_level, // Mask field of status word.
  input wire logic cpu_accept, // CPU takes the offered request.
  input wire logic [31:0] vbr, // Vector base of the CPU.
  output logic int_req, // Request offered to CPU.
  output logic [4:0] int_level, // Level of the offered request.
  output logic [7:0] int_vector, // Vector of the offered request.
  output logic [31:0] int_vec_addr, // Vector table entry address.
  output logic mask_load, // Pulse: load the CPU mask field.
  output logic [3:0] mask_value // New CPU mask field value.
);

  localparam logic [31:0] REG_IDX [`PIU_NREG] = '{
    `PIU_IDX_PRI_A, `PIU_IDX_PRI_B, `PIU_IDX_PRI_C, `PIU_IDX_PRI_D,
    `PIU_IDX_PRI_E, `PIU_IDX_PRI_F, `PIU_IDX_PRI_G, `PIU_IDX_PRI_H,
    `PIU_IDX_CTRL, `PIU_IDX_FLAGS};
  localparam piu_vec_t VEC [`PIU_NSRC] = `PIU_VEC_TABLE;
  localparam piu_fld_t FLD [`PIU_NSRC] = `PIU_FLD_TABLE;
  localparam logic [3:0] PIN_POS [6] = `PIU_PIN_POS;

  // Pin synchroniser and filter.
  logic [6:0] s1_q;
  logic [6:0] s2_q;
  logic [6:0] s3_q;
  logic [6:0] flt_q;
  wire [6:0] pin_raw = {irq_n_pins, nmi_pin};
  wire [6:0] flt_d = (s2_q & s3_q) | (flt_q & (s2_q ^ s3_q));
  wire [6:0] fall_w = flt_q & ~flt_d;
  wire [6:0] rise_w = ~flt_q & flt_d;

  // The first stage may go metastable, so only the second and third
  // are compared; this costs one cycle of latency on every pin.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= `PIU_PIN_RST;
    end else begin
      s1_q <= pin_raw;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s2_q <= `PIU_PIN_RST;
    end else begin
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s3_q <= `PIU_PIN_RST;
    end else begin
      s3_q <= s2_q;
    end
  end

  // The filter holds its old value while the two stages disagree.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_q <= `PIU_PIN_RST;
    end else begin
      flt_q <= flt_d;
    end
  end

  // Registers.
  piu_reg_t pri_q [`PIU_NPRI];
  piu_reg_t ctrl_q;
  logic nmi_pend_q;
  logic [5:0] lat_q;
  logic wp_q;
  logic [31:0] waddr_q;
  logic [1:0] wbe_q;
  logic hready_q;
  logic hresp_q;
  logic [31:0] hrdata_q;
  logic req_q;
  piu_level_t lvl_q;
  piu_vec_t vec_q;
  logic [31:0] vaddr_q;
  piu_src_t cur_q;
  logic mload_q;
  logic [3:0] mval_q;

  // Bus decode.
  wire ap = hsel & hready & htrans[1];
  wire ap_wr = ap & hwrite;
  wire ap_rd = ap & ~hwrite;
  wire sz_b = hsize == `PIU_HSIZE_BYTE;
  wire sz_h = hsize == `PIU_HSIZE_HALF;
  wire sz_w = ~sz_b & ~sz_h;
  // Bytes 2 and 3 of a word hold no register bits, so they enable no lane.
  wire half_lo = sz_h & ~haddr[1];
  wire byte0 = sz_b & (haddr[1:0] == `PIU_LANE0);
  wire byte1 = sz_b & (haddr[1:0] == `PIU_LANE1);
  wire lane0 = sz_w | half_lo | byte0;
  wire lane1 = sz_w | half_lo | byte1;
  wire [15:0] wmask = {{8{wbe_q[1]}}, {8{wbe_q[0]}}};
  wire [15:0] wd = hwdata[15:0];
  logic [`PIU_NREG-1:0] rhit;
  logic [`PIU_NREG-1:0] whit;

  for (genvar r = 0; r < `PIU_NREG; r++) begin : g_dec
    wire [31:0] ba = REG_IDX[r] << 2;
    assign rhit[r] = haddr[31:2] == ba[31:2];
    assign whit[r] = wp_q & (waddr_q[31:2] == ba[31:2]);
  end

  // Pin requests and flags.
  wire nonmaskable_edge_select = ctrl_q[`PIU_CTRL_NONMASKABLE_EDGE_SELECT];
  wire nmi_edge = nonmaskable_edge_select ? rise_w[0] : fall_w[0];
  wire flag_clr_wr = whit[`PIU_FLAGS_SLOT];
  logic [`PIU_NSRC-1:0] kill;
  logic [5:0] pin_req;
  piu_reg_t flags_w;
  logic [15:0] flag_vec [6];

  for (genvar k = 0; k < 6; k++) begin : g_pin
    wire edge_mode = ctrl_q[PIN_POS[k]];
    wire lvl_req = ~flt_q[k+1];
    wire sw_clr = flag_clr_wr & wmask[PIN_POS[k]] &
      ~wd[PIN_POS[k]];
    wire set_e = edge_mode & fall_w[k+1];
    wire clr_e = kill[k+1] | sw_clr;
    wire flag = edge_mode ? lat_q[k] : lvl_req;
    assign pin_req[k] = flag;
    assign flag_vec[k] = 16'(flag) << PIN_POS[k];
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lat_q[k] <= 1'b0;
      end else begin
        // A new edge outweighs a clear in the same cycle.
        lat_q[k] <= set_e | (lat_q[k] & ~clr_e);
      end
    end
  end

  assign flags_w = flag_vec[0] | flag_vec[1] | flag_vec[2] |
    flag_vec[3] | flag_vec[4] | flag_vec[5];

  // Source levels, one per source.
  wire [`PIU_NSRC-1:0] src_req = {periph_req, pin_req, nmi_pend_q};
  piu_level_t lvl [`PIU_NSRC];
  logic [`PIU_NSRC-1:0] act;

  for (genvar s = 0; s < `PIU_NSRC; s++) begin : g_src
    localparam piu_fld_t F = FLD[s];
    if (s == 0) begin : g_nmi
      assign lvl[s] = `PIU_NMI_LEVEL;
    end else begin : g_prog
      assign lvl[s] = {1'b0, pri_q[F[4:2]][{F[1:0], 2'b00} +: 4]};
    end
    assign kill[s] = cpu_accept & req_q & (cur_q == piu_src_t'(s));
    assign act[s] = src_req[s] & (lvl[s] != 5'h00) & ~kill[s];
  end

  // Lower index wins a tie: ties follow the fixed default order.
  piu_level_t best_lvl;
  piu_src_t best_src;
  always_comb begin
    best_lvl = 5'h00;
    best_src = `PIU_NMI_SRC;
    for (int s = 0; s < `PIU_NSRC; s++) begin
      if (act[s] && lvl[s] > best_lvl) begin
        best_lvl = lvl[s];
        best_src = piu_src_t'(s);
      end
    end
  end

  // Level 16 beats any four-bit mask, so the nonmaskable always passes.
  wire fwd = best_lvl > {1'b0, cpu_mask_level};
  wire [31:0] vtab = vbr + {22'h0, VEC[best_src], 2'b00};
  wire taken = cpu_accept & req_q;
  wire [3:0] new_mask = (cur_q == `PIU_NMI_SRC) ? `PIU_NMI_MASK :
    lvl_q[3:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_pend_q <= nmi_edge | (nmi_pend_q & ~kill[0]);
    end
  end

  // The offer is re-ranked every cycle, so a source taken at one edge
  // is already replaced by the next best request at that same edge.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= 1'b0;
    end else begin
      req_q <= fwd;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_q <= 5'h00;
    end else begin
      lvl_q <= best_lvl;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_q <= 8'h00;
    end else begin
      vec_q <= VEC[best_src];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vaddr_q <= 32'h0000_0000;
    end else begin
      vaddr_q <= vtab;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_q <= `PIU_NMI_SRC;
    end else begin
      cur_q <= best_src;
    end
  end

  // The new mask value holds after the pulse, so the core may load late.
  wire [3:0] mval_d = taken ? new_mask : mval_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mload_q <= 1'b0;
    end else begin
      mload_q <= taken;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mval_q <= 4'h0;
    end else begin
      mval_q <= mval_d;
    end
  end

  // Priority and control registers.
  for (genvar r = 0; r < `PIU_NPRI; r++) begin : g_pri
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pri_q[r] <= `PIU_PRI_RST;
      end else if (whit[r]) begin
        pri_q[r] <= (pri_q[r] & ~wmask) | (wd & wmask);
      end
    end
  end

  wire [15:0] ctrl_wm = wmask & `PIU_CTRL_WMASK;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `PIU_CTRL_RST;
    end else if (whit[`PIU_CTRL_SLOT]) begin
      ctrl_q <= (ctrl_q & ~ctrl_wm) | (wd & ctrl_wm);
    end
  end

  // Read mux.
  wire [15:0] ctrl_rd = ctrl_q |
    (16'(flt_q[0]) << `PIU_CTRL_NMI_LVL);
  piu_reg_t rd_w;
  always_comb begin
    rd_w = 16'h0000;
    for (int r = 0; r < `PIU_NPRI; r++) begin
      if (rhit[r]) begin
        rd_w = pri_q[r];
      end
    end
    if (rhit[`PIU_CTRL_SLOT]) begin
      rd_w = ctrl_rd;
    end
    if (rhit[`PIU_FLAGS_SLOT]) begin
      rd_w = flags_w;
    end
  end

  // Writes take one wait state so a following read sees the new value.
  // Write data arrive a cycle after the address, so the address and the
  // lanes are held for that cycle; reads answer with no wait state.
  wire [31:0] waddr_d = ap_wr ? haddr : waddr_q;
  wire [1:0] wbe_d = ap_wr ? {lane1, lane0} : wbe_q;
  wire hready_d = ~ap_wr;
  wire [31:0] hrdata_d = ap_rd ? {16'h0000, rd_w} : hrdata_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= 1'b0;
    end else begin
      wp_q <= ap_wr;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      waddr_q <= 32'h0000_0000;
    end else begin
      waddr_q <= waddr_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wbe_q <= 2'h0;
    end else begin
      wbe_q <= wbe_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hready_q <= 1'b1;
    end else begin
      hready_q <= hready_d;
    end
  end

  // No access is ever refused, so the response stays OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;
  assign int_req = req_q;
  assign int_level = lvl_q;
  assign int_vector = vec_q;
  assign int_vec_addr = vaddr_q;
  assign mask_load = mload_q;
  assign mask_value = mval_q;

endmodule

// ---- tb/piu_checker.sv ----
`timescale 1ns/1ps

module piu_checker(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hsel, // Select.
  input wire logic [1:0] htrans, // Type.
  input wire logic hwrite, // Write.
  input wire logic hready, // Ready in.
  input wire logic hreadyout, // Ready out.
  input wire logic [3:0] cpu_mask_level, // Mask.
  input wire logic cpu_accept, // Accept.
  input wire logic [31:0] vbr, // Base.
  input wire logic int_req, // Request.
  input wire logic [4:0] int_level, // Level.
  input wire logic [7:0] int_vector, // Vector.
  input wire logic [31:0] int_vec_addr, // Entry.
  input wire logic mask_load, // Load.
  input wire logic [3:0] mask_value // New mask.
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire taken = cpu_accept && int_req;
  wire wr_go = hsel && hready && htrans[1] && hwrite;
  sequence load_pulse;
    mask_load ##1 !mask_load;
  endsequence
  sequence write_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  chk_level_nonzero: assert property (int_req |-> int_level != 5'h00)
    else $error("request at level zero");
  chk_above_mask: assert property (
    int_req |-> int_level > {1'b0, $past(cpu_mask_level)})
    else $error("request not above mask");
  chk_nmi_vector: assert property (
    int_req && int_level == 5'h10 |-> int_vector == 8'h0B)
    else $error("wrong nonmaskable vector");
  chk_entry_addr: assert property (
    int_req |-> int_vec_addr == vbr + {22'h0, int_vector, 2'h0})
    else $error("wrong table address");
  chk_mask_pulse: assert property (taken |=> load_pulse)
    else $error("no load pulse");
  chk_mask_value: assert property (taken |=> mask_value ==
    (($past(int_level) == 5'h10) ? 5'h0F : $past(int_level)))
    else $error("wrong mask value");
  chk_stray_load: assert property (mask_load |-> $past(taken))
    else $error("load without accept");
  chk_write_wait: assert property (wr_go |=> write_wait)
    else $error("bad write wait");
endmodule

// ---- tb/piu_cpu_model.sv ----
`timescale 1ns/1ps

module piu_cpu_model(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic en, // Take requests.
  input wire logic unmask, // Clear mask.
  input wire logic int_req, // Request.
  input wire logic mask_load, // Load.
  input wire logic [3:0] mask_value, // New mask.
  output logic cpu_accept, // Accept.
  output logic [3:0] cpu_mask_level // Mask.
);
  logic [1:0] dly_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_accept <= 1'b0;
      cpu_mask_level <= 4'h0;
      dly_q <= 2'h0;
    end else begin
      dly_q <= int_req ? dly_q + 2'h1 : 2'h0;
      // A late accept mimics a core stuck in a delay slot.
      cpu_accept <= en && int_req && !cpu_accept && dly_q == 2'h3;
      if (mask_load) begin
        cpu_mask_level <= mask_value;
      end else if (unmask) begin
        cpu_mask_level <= 4'h0;
      end
    end
  end
endmodule

// ---- tb/tb_prioritized_interrupt_controller.sv ----
`timescale 1ns/1ps
`include "piu_map.svh"
`define CHK(a, e) begin \
  samples_checked++; \
  if ((a) !== (e)) begin \
    err_count++; \
    $display("[ERR] %0t got %h want %h", $time, a, e); \
  end \
end

module tb_prioritized_interrupt_controller
  import piu_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h1;
  logic [31:0] hwdata = 32'h0;
  logic nmi_pin = 1'b0;
  logic [5:0] irq_n_pins = 6'h3F;
  logic [19:0] periph_req = 20'h0;
  logic [31:0] vbr = 32'h00001000;
  logic en = 1'b0;
  logic unmask = 1'b0;
  logic hreadyout, hresp, int_req, mask_load, cpu_accept;
  logic [31:0] hrdata, int_vec_addr, v;
  logic [4:0] int_level;
  logic [7:0] int_vector;
  logic [3:0] mask_value, cpu_mask_level;
  piu_reg_t r;
  int err_count = 0;
  int samples_checked = 0;
  piu_top i_dut(.hready(hreadyout), .*);
  piu_cpu_model i_cpu(.*);

  initial forever #2.5 hclk = ~hclk;

  task automatic bus(input logic w, input logic [31:0] idx,
      input logic [2:0] sz, input logic [1:0] off, input piu_reg_t d);
    @(posedge hclk);
    haddr <= (idx << 2) + off;
    hsize <= sz;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {d, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  task automatic wr(input logic [31:0] idx, input piu_reg_t d);
    bus(1'b1, idx, 3'h1, 2'h0, d);
  endtask

  task automatic rd(input logic [31:0] idx);
    bus(1'b0, idx, 3'h1, 2'h0, 16'h0000);
  endtask

  task automatic wait_req(input logic want);
    repeat (40) begin
      if (int_req === want) break;
      @(posedge hclk);
      #1;
    end
  endtask

  task automatic settle(input logic [3:0] m);
    repeat (40) begin
      if (cpu_mask_level === m) break;
      @(posedge hclk);
      #1;
    end
  endtask

  function automatic piu_reg_t lfsr(input piu_reg_t s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic piu_reg_t exp_ctrl(input piu_reg_t w, input logic n);
    return (w & `PIU_CTRL_WMASK) | {n, 15'h0000};
  endfunction

  task tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      rd(`PIU_IDX_PRI_A + 2 * i);
      `CHK(v, 32'h0)
      `CHK(hresp, 1'b0)
    end
    r = 16'hF247;
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      wr(`PIU_IDX_PRI_A + 2 * r[2:0], r);
      rd(`PIU_IDX_PRI_A + 2 * r[2:0]);
      `CHK(v[15:0], r)
    end
    wr(`PIU_IDX_PRI_A, 16'h1234);
    bus(1'b1, `PIU_IDX_PRI_A, `PIU_HSIZE_BYTE, 2'h1, 16'hA5A5);
    rd(`PIU_IDX_PRI_A);
    `CHK(v[15:0], 16'hA534)
    bus(1'b0, `PIU_IDX_PRI_A, `PIU_HSIZE_BYTE, 2'h1, 16'h0000);
    `CHK(v[15:8], 8'hA5)
    bus(1'b1, `PIU_IDX_PRI_B, 3'h2, 2'h0, 16'hBEEF);
    rd(`PIU_IDX_PRI_B);
    `CHK(v[15:0], 16'hBEEF)
    rd(`PIU_IDX_FLAGS + 2);
    `CHK(v, 32'h0)
    wr(`PIU_IDX_CTRL, 16'hFFFF);
    rd(`PIU_IDX_CTRL);
    `CHK(v[15:0], exp_ctrl(16'hFFFF, 1'b0))
    // Level sense on pins 0 and 1 at one level shows the tie order.
    wr(`PIU_IDX_CTRL, 16'h0000);
    wr(`PIU_IDX_PRI_A, 16'h5500);
    irq_n_pins <= 6'h3C;
    wait_req(1'b1);
    `CHK(int_level, 5'h05)
    `CHK(int_vector, 8'h40)
    rd(`PIU_IDX_FLAGS);
    `CHK(v[7], 1'b1)
    irq_n_pins <= 6'h3F;
    wait_req(1'b0);
    `CHK(int_req, 1'b0)
    wr(`PIU_IDX_PRI_A, 16'h0000);
    irq_n_pins <= 6'h3E;
    repeat (10) @(posedge hclk);
    `CHK(int_req, 1'b0)
    irq_n_pins <= 6'h3F;
    wr(`PIU_IDX_PRI_A, 16'h5000);
    wr(`PIU_IDX_CTRL, 16'h0080);
    irq_n_pins <= 6'h3E;
    repeat (3) @(posedge hclk);
    irq_n_pins <= 6'h3F;
    wait_req(1'b1);
    repeat (10) @(posedge hclk);
    `CHK(int_req, 1'b1)
    rd(`PIU_IDX_FLAGS);
    `CHK(v[7], 1'b1)
    wr(`PIU_IDX_FLAGS, 16'hFF7F);
    wait_req(1'b0);
    `CHK(int_req, 1'b0)
    irq_n_pins <= 6'h3E;
    repeat (3) @(posedge hclk);
    irq_n_pins <= 6'h3F;
    en <= 1'b1;
    settle(4'h5);
    `CHK(cpu_mask_level, 4'h5)
    rd(`PIU_IDX_FLAGS);
    `CHK(v[7], 1'b0)
    unmask <= 1'b1;
    en <= 1'b0;
    wr(`PIU_IDX_PRI_D, 16'h7000);
    unmask <= 1'b0;
    periph_req <= 20'h00003;
    wait_req(1'b1);
    `CHK(int_vector, 8'h58)
    en <= 1'b1;
    settle(4'h7);
    `CHK(cpu_mask_level, 4'h7)
    wait_req(1'b0);
    `CHK(int_req, 1'b0)
    periph_req <= 20'h00000;
    en <= 1'b0;
    wr(`PIU_IDX_CTRL, 16'h0100);
    nmi_pin <= 1'b1;
    wait_req(1'b1);
    `CHK(int_level, 5'h10)
    rd(`PIU_IDX_CTRL);
    `CHK(v[15:0], exp_ctrl(16'h0100, 1'b1))
    en <= 1'b1;
    settle(4'hF);
    `CHK(cpu_mask_level, 4'hF)
    en <= 1'b0;
    wr(`PIU_IDX_CTRL, 16'h0000);
    nmi_pin <= 1'b0;
    wait_req(1'b1);
    `CHK(int_vector, 8'h0B)
    tally_and_finish();
  end
endmodule

bind piu_top piu_checker i_chk(.*);
